// ---- rtl/kpdr_display.sv ----
// Notes on behaviour
// R1: Gas mode: B holds low nibble, A top two
// R2: Select picks bank before each access
// R3: Gas pointer alternates A0, B0, A1, B1
// R4: Individual mode: bank A/B on own outputs
// R5: Gas: 6-bit char, A2 clock, A3 reset
// R6: Walking one on scans; store return row
// R7: Eight chars per scan, row half toggles
// R8: Clear-all resets logic, fills blanks
// R9: Select 0100/0101 picks bank, keeps showing
// R10: Select 0110/0111 picks bank, holds inactive
// R11: Display-init zeroes pointer, blanks, sets depths
// R12: Sequential write stores, shifts, increments
// R13: Sequential read returns, increments, no shift
// R14: In-place write stores, pointer unchanged
// R15: In-place read returns, pointer unchanged
// R16: Add char plus carry to accumulator
// R17: Subtract char and borrow from accumulator
// R18: Eight-deep bank scans twice as often
// R19: Reset sets both banks sixteen deep
// R20: Eight-deep shows low eight, rest storage
// R21: Sequential ops walk all sixteen, writes rotate all
// R22: Gas select 0110/0111 blanks with hex 20
// R23: Mode-set takes display and input modes
// R24: Respond only after select with address 01
// R25: Individual pointer wraps within its bank
`timescale 1ns/1ps
`default_nettype none
module kpdr_display #(
  parameter int unsigned STEP_CYCLES = kpdr_pkg::STEP_CYCLES
) (
  input wire logic pclk, // Clock, 200 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [7:0] return_inputs, // Row returns from the matrix
  output logic [7:0] scan_outputs, // One-hot scan drive
  output logic row_half_toggle, // High during second eight digits
  output logic [3:0] bank_a_outputs, // Bank A digit lines
  output logic [3:0] bank_b_outputs // Bank B digit lines
);
  localparam int CW = $clog2(STEP_CYCLES + 1);
  localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

  logic [3:0] mem_a [16];
  logic [3:0] mem_b [16];
  logic [7:0] sense_q [8];
  logic [1:0] disp_mode_q;
  logic [1:0] in_mode_q;
  logic enabled_q;
  logic blank_a_q;
  logic blank_b_q;
  logic depth8_a_q;
  logic depth8_b_q;
  logic [3:0] ptr_pos_q;
  logic ptr_bank_q;
  logic [3:0] off_a_q;
  logic [3:0] off_b_q;
  logic [7:0] sel_q;
  logic [12:0] cmd_q;
  logic [3:0] res_acc_q;
  logic res_carry_q;
  logic [CW-1:0] step_cnt_q;
  logic [2:0] scan_pos_q;
  logic row_half_q;
  logic gas_phase_q;
  logic [3:0] gas_char_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] scan_q;
  logic [2:0] scan_row_q;
  logic row_half_out_q;
  logic [3:0] out_a_q;
  logic [3:0] out_b_q;

  // Bus phase and decoded command
  logic access;
  logic wr_sel;
  logic wr_cmd;
  logic gas;
  logic [7:0] opcode;
  logic [3:0] acc_in;
  logic carry_in;
  logic [3:0] cur_char;
  logic step_tick;
  logic rd_hit;

  assign access = psel && penable && pready_q;
  assign wr_sel = access && pwrite && (paddr == kpdr_pkg::SELECT_OFS);
  assign wr_cmd = access && pwrite && (paddr == kpdr_pkg::COMMAND_OFS) && enabled_q; // R24
  assign gas = (disp_mode_q != kpdr_pkg::DISP_INDIVIDUAL);
  assign opcode = pwdata[7:0];
  assign acc_in = pwdata[11:8];
  assign carry_in = pwdata[12];
  assign cur_char = ptr_bank_q ? mem_b[ptr_pos_q] : mem_a[ptr_pos_q];
  assign step_tick = (step_cnt_q == STEP_LAST);

  // Blank nibble for a bank in the current display mode
  function automatic logic [3:0] blank_nib(input logic is_gas, input logic bank_b);
    if (!is_gas)
      blank_nib = kpdr_pkg::BLANK_INDIV;
    else if (bank_b)
      blank_nib = kpdr_pkg::BLANK_GAS_B;
    else
      blank_nib = kpdr_pkg::BLANK_GAS_A;
  endfunction : blank_nib

  // Address decode shared by the read mux and the error flag
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == kpdr_pkg::SELECT_OFS) || (a == kpdr_pkg::COMMAND_OFS) ||
                  (a == kpdr_pkg::RESULT_OFS) || (a == kpdr_pkg::STATUS_OFS) ||
                  ((a[7:5] == kpdr_pkg::SENSE_BASE_OFS[7:5]) && (a[1:0] == 2'h0));
  endfunction : addr_mapped

  assign rd_hit = addr_mapped(paddr);

  // One wait state so read data can come from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !rd_hit;
      prdata_q <= 32'h00000000;
      if (psel && penable && !pready_q && !pwrite)
      begin
        case (paddr)
          kpdr_pkg::SELECT_OFS: prdata_q <= {24'h000000, sel_q};
          kpdr_pkg::COMMAND_OFS: prdata_q <= {19'h00000, cmd_q};
          kpdr_pkg::RESULT_OFS: prdata_q <= {27'h0000000, res_carry_q, res_acc_q};
          kpdr_pkg::STATUS_OFS: prdata_q <= {14'h0000, row_half_q, scan_pos_q, ptr_bank_q,
                                             ptr_pos_q, blank_b_q, blank_a_q, enabled_q,
                                             depth8_b_q, depth8_a_q, disp_mode_q, in_mode_q};
          default:
          begin
            if (rd_hit)
              prdata_q <= {24'h000000, sense_q[paddr[4:2]]};
          end
        endcase
      end
    end
  end

  // Selection, modes, depths and blanking flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enabled_q <= 1'b0;
      sel_q <= 8'h00;
      cmd_q <= 13'h0000;
      disp_mode_q <= kpdr_pkg::DISP_RESET; // R23
      in_mode_q <= kpdr_pkg::IN_RESET;
      depth8_a_q <= 1'b0; // R19
      depth8_b_q <= 1'b0; // R19
      blank_a_q <= 1'b0;
      blank_b_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_sel)
      begin
        sel_q <= pwdata[7:0];
        enabled_q <= (pwdata[7:6] == kpdr_pkg::CHIP_ADDR); // R24
        if (pwdata[7:6] == kpdr_pkg::CHIP_ADDR)
        begin
          if (gas)
          begin
            blank_a_q <= pwdata[5]; // R22
            blank_b_q <= pwdata[5]; // R22
          end
          else if (pwdata[4])
            blank_b_q <= pwdata[5]; // R9 R10
          else
            blank_a_q <= pwdata[5]; // R9 R10
        end
      end
      if (wr_cmd)
      begin
        cmd_q <= pwdata[12:0];
        case (opcode)
          kpdr_pkg::MODE_SET_CMD:
          begin
            disp_mode_q <= acc_in[3:2]; // R23
            in_mode_q <= acc_in[1:0]; // R23
          end
          kpdr_pkg::DISPLAY_INIT_CMD:
          begin
            depth8_b_q <= acc_in[3]; // R11
            depth8_a_q <= acc_in[2]; // R11
          end
          kpdr_pkg::CLEAR_ALL_CMD:
          begin
            blank_a_q <= 1'b0; // R8
            blank_b_q <= 1'b0; // R8
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Pointer and display rotation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_pos_q <= 4'h0;
      ptr_bank_q <= 1'b0;
      off_a_q <= 4'h0;
      off_b_q <= 4'h0;
    end
    else if (ce)
    begin
      if (wr_sel && (pwdata[7:6] == kpdr_pkg::CHIP_ADDR))
      begin
        ptr_bank_q <= pwdata[4]; // R2
        ptr_pos_q <= pwdata[3:0]; // R9 R10 R22
      end
      else if (wr_cmd)
      begin
        case (opcode)
          kpdr_pkg::DISPLAY_INIT_CMD, kpdr_pkg::CLEAR_ALL_CMD:
          begin
            ptr_pos_q <= 4'h0; // R11 R8
            ptr_bank_q <= 1'b0;
            off_a_q <= 4'h0;
            off_b_q <= 4'h0;
          end
          kpdr_pkg::SEQUENTIAL_WRITE_CMD, kpdr_pkg::SEQUENTIAL_READ_CMD:
          begin
            if (gas)
            begin
              ptr_bank_q <= !ptr_bank_q; // R3
              if (ptr_bank_q)
                ptr_pos_q <= 4'(ptr_pos_q + 4'h1); // R3
            end
            else
              ptr_pos_q <= 4'(ptr_pos_q + 4'h1); // R21 R25
            if (opcode == kpdr_pkg::SEQUENTIAL_WRITE_CMD)
            begin
              // Shift by offset so the whole bank rotates, used or not
              if (gas || !ptr_bank_q)
                off_a_q <= 4'(off_a_q + 4'h1); // R12 R21
              if (gas || ptr_bank_q)
                off_b_q <= 4'(off_b_q + 4'h1); // R12 R21
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Display memory; reset fills the gas blank since reset mode is gas
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        mem_a[i] <= kpdr_pkg::BLANK_GAS_A;
        mem_b[i] <= kpdr_pkg::BLANK_GAS_B;
      end
    end
    else if (ce && wr_cmd)
    begin
      case (opcode)
        kpdr_pkg::DISPLAY_INIT_CMD, kpdr_pkg::CLEAR_ALL_CMD:
        begin
          for (int i = 0; i < 16; i++)
          begin
            mem_a[i] <= blank_nib(gas, 1'b0); // R8 R11 R1
            mem_b[i] <= blank_nib(gas, 1'b1); // R8 R11 R1
          end
        end
        kpdr_pkg::SEQUENTIAL_WRITE_CMD, kpdr_pkg::IN_PLACE_WRITE_CMD:
        begin
          if (ptr_bank_q)
            mem_b[ptr_pos_q] <= acc_in; // R12 R14 R20
          else
            mem_a[ptr_pos_q] <= acc_in; // R12 R14 R20
        end
        default:
        begin
        end
      endcase
    end
  end

  // Accumulator results for read, add and subtract
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_acc_q <= 4'h0;
      res_carry_q <= 1'b0;
    end
    else if (ce && wr_cmd)
    begin
      case (opcode)
        kpdr_pkg::SEQUENTIAL_READ_CMD, kpdr_pkg::IN_PLACE_READ_CMD:
        begin
          res_acc_q <= cur_char; // R13 R15
          res_carry_q <= carry_in;
        end
        kpdr_pkg::ADD_CHAR_CMD:
          {res_carry_q, res_acc_q} <= 5'({1'b0, acc_in} + {1'b0, cur_char} + {4'h0, carry_in}); // R16
        kpdr_pkg::SUBTRACT_CHAR_CMD:
          {res_carry_q, res_acc_q} <= 5'({1'b0, acc_in} - {1'b0, cur_char} - {4'h0, carry_in}); // R17
        default:
        begin
        end
      endcase
    end
  end

  // Refresh step timer; one step per displayed digit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_cnt_q <= '0;
    else if (ce)
      step_cnt_q <= step_tick ? '0 : CW'(step_cnt_q + 1'b1);
  end

  // Scan walk and row half; eight-deep banks repeat each half for double rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_pos_q <= 3'h0;
      row_half_q <= 1'b0;
      gas_phase_q <= 1'b0;
      gas_char_q <= 4'h0;
    end
    else if (ce)
    begin
      if (wr_cmd && (opcode == kpdr_pkg::CLEAR_ALL_CMD))
      begin
        scan_pos_q <= 3'h0; // R8
        row_half_q <= 1'b0;
        gas_phase_q <= 1'b0;
        gas_char_q <= 4'h0;
      end
      else if (step_tick)
      begin
        scan_pos_q <= 3'(scan_pos_q + 3'h1); // R6
        if (scan_pos_q == 3'h7)
          row_half_q <= !row_half_q; // R7
        gas_phase_q <= !gas_phase_q;
        if (gas_phase_q)
          gas_char_q <= 4'(gas_char_q + 4'h1);
      end
    end
  end

  // Return rows land in the buffer slot of the active scan line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int r = 0; r < 8; r++)
        sense_q[r] <= 8'h00;
    end
    else if (ce)
    begin
      if (wr_cmd && (opcode == kpdr_pkg::CLEAR_ALL_CMD))
      begin
        for (int r = 0; r < 8; r++)
          sense_q[r] <= 8'h00; // R8
      end
      else if ((in_mode_q == kpdr_pkg::IN_SENSOR) || (in_mode_q == kpdr_pkg::IN_SCAN_KBD))
        sense_q[scan_row_q] <= return_inputs; // R6
    end
  end

  // Output stage; every pin comes from a flop
  logic [3:0] idx_a;
  logic [3:0] idx_b;
  logic [3:0] gas_idx_a;
  logic [3:0] gas_idx_b;
  assign idx_a = 4'((depth8_a_q ? {1'b0, scan_pos_q} : {row_half_q, scan_pos_q}) + off_a_q); // R18 R20
  assign idx_b = 4'((depth8_b_q ? {1'b0, scan_pos_q} : {row_half_q, scan_pos_q}) + off_b_q); // R18 R20
  assign gas_idx_a = 4'(gas_char_q + off_a_q);
  assign gas_idx_b = 4'(gas_char_q + off_b_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_q <= 8'h00;
      scan_row_q <= 3'h0;
      row_half_out_q <= 1'b0;
      out_a_q <= 4'h0;
      out_b_q <= 4'h0;
    end
    else if (ce)
    begin
      // Row index and half go out with the scan pins, else returns land one slot late
      scan_q <= 8'h01 << scan_pos_q; // R6 R7
      scan_row_q <= scan_pos_q; // R6
      row_half_out_q <= row_half_q; // R7
      if (gas)
      begin
        // Reset marks character zero; clock high in second half of each character
        out_a_q[3] <= (gas_char_q == 4'h0); // R5
        out_a_q[2] <= gas_phase_q; // R5
        out_a_q[1:0] <= blank_a_q ? kpdr_pkg::BLANK_GAS_A[1:0] : mem_a[gas_idx_a][1:0]; // R1 R5 R22
        out_b_q <= blank_b_q ? kpdr_pkg::BLANK_GAS_B : mem_b[gas_idx_b]; // R1 R5 R22
      end
      else
      begin
        out_a_q <= blank_a_q ? kpdr_pkg::BLANK_INDIV : mem_a[idx_a]; // R4 R10
        out_b_q <= blank_b_q ? kpdr_pkg::BLANK_INDIV : mem_b[idx_b]; // R4 R10
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign scan_outputs = scan_q;
  assign row_half_toggle = row_half_out_q;
  assign bank_a_outputs = out_a_q;
  assign bank_b_outputs = out_b_q;
endmodule : kpdr_display
`default_nettype wire

// ---- inc/kpdr_pkg.sv ----
`default_nettype none
package kpdr_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] SELECT_OFS = 8'h00;
  localparam logic [7:0] COMMAND_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] SENSE_BASE_OFS = 8'h20;
  // Command opcodes
  localparam logic [7:0] MODE_SET_CMD = 8'hE4;
  localparam logic [7:0] DISPLAY_INIT_CMD = 8'hE5;
  localparam logic [7:0] CLEAR_ALL_CMD = 8'hE7;
  localparam logic [7:0] SEQUENTIAL_WRITE_CMD = 8'hE0;
  localparam logic [7:0] SEQUENTIAL_READ_CMD = 8'hE9;
  localparam logic [7:0] IN_PLACE_WRITE_CMD = 8'hE1;
  localparam logic [7:0] IN_PLACE_READ_CMD = 8'hEF;
  localparam logic [7:0] ADD_CHAR_CMD = 8'hEB;
  localparam logic [7:0] SUBTRACT_CHAR_CMD = 8'hE8;
  // Select fields
  localparam logic [1:0] CHIP_ADDR = 2'h1;
  // Display modes (accumulator bits 3..2)
  localparam logic [1:0] DISP_GAS20 = 2'h0;
  localparam logic [1:0] DISP_INDIVIDUAL = 2'h1;
  localparam logic [1:0] DISP_GAS18 = 2'h2;
  localparam logic [1:0] DISP_GAS16 = 2'h3;
  // Input modes (accumulator bits 1..0)
  localparam logic [1:0] IN_SENSOR = 2'h0;
  localparam logic [1:0] IN_SCAN_KBD = 2'h1;
  localparam logic [1:0] IN_ENCODED = 2'h2;
  // Values after reset
  localparam logic [1:0] DISP_RESET = DISP_GAS16;
  localparam logic [1:0] IN_RESET = IN_SCAN_KBD;
  // Blank codes: all ones, or hex 20 split over banks
  localparam logic [3:0] BLANK_INDIV = 4'hF;
  localparam logic [3:0] BLANK_GAS_A = 4'h2;
  localparam logic [3:0] BLANK_GAS_B = 4'h0;
  // Refresh timing
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned SCAN_HZ_DEEP = 180;
  localparam int unsigned CHARS_DEEP = 16;
  localparam int unsigned STEP_CYCLES = CLK_HZ / (SCAN_HZ_DEEP * CHARS_DEEP);
endpackage : kpdr_pkg
`default_nettype wire

// ---- bench/kpdr_display_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module kpdr_display_assertions (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [7:0] scan_outputs, // Scan drive
  input wire logic row_half_toggle // Row half
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] scan_prev_q;
  logic mapped;
  // Last scan pattern, so the walk can be judged step by step
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      scan_prev_q <= 8'h00;
    else
      scan_prev_q <= scan_outputs;
  // Register map; anything outside must be refused
  assign mapped = paddr[1:0] == 2'h0 && (paddr < 8'h10 || (paddr >= 8'h20 && paddr < 8'h40));
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_time: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not in second access cycle");
  chk_ready_req: assert property (pready |-> psel && penable)
    else $error("pready without a transfer");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside ready");
  chk_scan_hot: assert property ($past(presetn) |-> $onehot(scan_outputs))
    else $error("scan lines not one-hot");
  chk_scan_walk: assert property (scan_outputs != scan_prev_q && scan_outputs != 8'h01
    |-> scan_outputs == {scan_prev_q[6:0], 1'b0})
    else $error("scan one did not shift by one line");
  chk_half_wrap: assert property ($changed(row_half_toggle) |-> scan_outputs == 8'h01)
    else $error("row half changed away from scan wrap");
  cov_error: cover property (pready && pslverr);
  cov_half: cover property ($rose(row_half_toggle));
  cov_wrap: cover property (scan_prev_q == 8'h80 && scan_outputs == 8'h01);
endmodule : kpdr_display_assertions
bind kpdr_display kpdr_display_assertions i_kpdr_display_assertions (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scan_outputs(scan_outputs),
  .row_half_toggle(row_half_toggle));
`default_nettype wire

// ---- bench/kpdr_keys.sv ----
`timescale 1ns/1ps
`default_nettype none
module kpdr_keys (
  input wire logic [7:0] scan_outputs, // Driven rows
  input wire logic [63:0] key_map, // Closed keys, eight per row
  output logic [7:0] return_inputs // Return lines
);
  // Rows are OR-tied; open returns are pulled low
  always_comb
  begin
    return_inputs = 8'h00;
    for (int r = 0; r < 8; r++)
      if (scan_outputs[r])
        return_inputs |= key_map[r * 8 +: 8];
  end
endmodule : kpdr_keys
`default_nettype wire

// ---- bench/test_keypad_display_refresh_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_keypad_display_refresh_regs;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, row_half_toggle, err;
  logic [7:0] paddr, return_inputs, scan_outputs;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] bank_a_outputs, bank_b_outputs;
  logic [63:0] key_map;
  int miscompares, total_checks, cycles, seed, ptr, bk, gas, v, e;
  int ma[16], mb[16];
  kpdr_display #(.STEP_CYCLES(4)) i_kpdr_display (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .return_inputs(return_inputs),
    .scan_outputs(scan_outputs), .row_half_toggle(row_half_toggle),
    .bank_a_outputs(bank_a_outputs), .bank_b_outputs(bank_b_outputs));
  kpdr_keys i_kpdr_keys (.scan_outputs(scan_outputs), .key_map(key_map),
    .return_inputs(return_inputs));
  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; waits for pready, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n == 20)
    begin
      miscompares++;
      complete_run();
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cmd(input logic [7:0] op, input int acc, input int c);
    apb(1'b1, kpdr_pkg::COMMAND_OFS, {19'h0, 1'(c), 4'(acc), op});
  endtask : cmd
  task automatic sel(input int b, input int n, input int blank);
    apb(1'b1, kpdr_pkg::SELECT_OFS, {24'h0, 2'h1, 1'(blank), 1'(b), 4'(n)});
    bk = b;
    ptr = n;
  endtask : sel
  function automatic int get();
    return bk != 0 ? mb[ptr] : ma[ptr];
  endfunction : get
  function automatic void put(input int x);
    if (bk != 0)
      mb[ptr] = x;
    else
      ma[ptr] = x;
  endfunction : put
  // Model pointer step: gas alternates banks, individual wraps in bank
  function automatic void inc();
    if (gas != 0 && bk == 0)
      bk = 1;
    else
    begin
      bk = 0 + (gas == 0 ? bk : 0);
      ptr = (ptr + 1) % 16;
    end
  endfunction : inc
  function automatic int slot();
    for (int i = 0; i < 8; i++)
      if (scan_outputs[i])
        return i + 8 * row_half_toggle;
    return 0;
  endfunction : slot
  task automatic chk_ptr();
    apb(1'b0, kpdr_pkg::STATUS_OFS, 32'h0);
    chk("pointer", {27'h0, rv[13:9]}, 32'(bk * 16 + ptr));
  endtask : chk_ptr
  task automatic rdc(input logic [7:0] op);
    e = get();
    cmd(op, 0, 0);
    apb(1'b0, kpdr_pkg::RESULT_OFS, 32'h0);
    chk("char", {28'h0, rv[3:0]}, 32'(e));
  endtask : rdc
  task automatic seq(input logic [7:0] op);
    for (int i = 0; i < 3; i++)
    begin
      v = $random(seed) & 15;
      if (op == kpdr_pkg::SEQUENTIAL_WRITE_CMD)
        cmd(op, v, 0);
      if (op == kpdr_pkg::SEQUENTIAL_WRITE_CMD)
        put(v);
      else
        rdc(op);
      inc();
      chk_ptr();
    end
  endtask : seq
  // Main sequence
  initial
  begin
    seed = 1064;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    key_map = {$random(seed), $random(seed)};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, kpdr_pkg::STATUS_OFS, 32'h0);
    chk("status", rv & 32'h3FFF, 32'h0000000D);
    repeat (40) @(posedge pclk);
    for (int r = 0; r < 8; r++)
    begin
      apb(1'b0, 8'(kpdr_pkg::SENSE_BASE_OFS + 4 * r), 32'h0);
      chk("sense", rv, 32'(key_map[r * 8 +: 8]));
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    cmd(kpdr_pkg::MODE_SET_CMD, 5, 0);
    apb(1'b0, kpdr_pkg::STATUS_OFS, 32'h0);
    chk("disabled", rv & 32'h7F, 32'h0000000D);
    $display("test reset done");
    sel(0, 0, 0);
    cmd(kpdr_pkg::MODE_SET_CMD, 5, 0);
    cmd(kpdr_pkg::DISPLAY_INIT_CMD, 12, 0);
    apb(1'b0, kpdr_pkg::STATUS_OFS, 32'h0);
    chk("init", rv & 32'h3FFF, 32'h00000075);
    cmd(kpdr_pkg::DISPLAY_INIT_CMD, 0, 0);
    foreach (ma[i])
    begin
      ma[i] = 15;
      mb[i] = 15;
    end
    rdc(kpdr_pkg::IN_PLACE_READ_CMD);
    for (int i = 0; i < 8; i++)
    begin
      sel($random(seed) & 1, $random(seed) & 15, 0);
      v = $random(seed) & 15;
      cmd(kpdr_pkg::IN_PLACE_WRITE_CMD, v, 0);
      put(v);
      rdc(kpdr_pkg::IN_PLACE_READ_CMD);
      chk_ptr();
    end
    sel(1, 14, 0);
    seq(kpdr_pkg::SEQUENTIAL_WRITE_CMD);
    sel(1, 14, 0);
    seq(kpdr_pkg::SEQUENTIAL_READ_CMD);
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed) & 15;
      e = i[1] ? v - get() - i[0] : v + get() + i[0];
      cmd(i[1] ? kpdr_pkg::SUBTRACT_CHAR_CMD : kpdr_pkg::ADD_CHAR_CMD, v, i[0]);
      apb(1'b0, kpdr_pkg::RESULT_OFS, 32'h0);
      chk("arith", {27'h0, rv[4:0]}, 32'(e & 31));
    end
    repeat (12)
    begin
      repeat (($random(seed) & 7) + 1) @(posedge pclk);
      v = slot();
      chk("digit_a", 32'(bank_a_outputs), 32'(ma[v]));
      chk("digit_b", 32'(bank_b_outputs), 32'(mb[(v + 3) % 16]));
    end
    sel(0, 0, 1);
    repeat (12) @(posedge pclk);
    repeat (8) @(posedge pclk) chk("blank_a", 32'(bank_a_outputs), 32'hF);
    $display("test individual done");
    cmd(kpdr_pkg::MODE_SET_CMD, 13, 0);
    cmd(kpdr_pkg::DISPLAY_INIT_CMD, 0, 0);
    gas = 1;
    foreach (ma[i])
    begin
      ma[i] = 2;
      mb[i] = 0;
    end
    sel(0, 0, 0);
    seq(kpdr_pkg::SEQUENTIAL_WRITE_CMD);
    sel(0, 0, 0);
    seq(kpdr_pkg::SEQUENTIAL_READ_CMD);
    cmd(kpdr_pkg::CLEAR_ALL_CMD, 0, 0);
    foreach (ma[i])
    begin
      ma[i] = 2;
      mb[i] = 0;
    end
    sel(0, 0, 0);
    rdc(kpdr_pkg::IN_PLACE_READ_CMD);
    sel(1, 0, 0);
    rdc(kpdr_pkg::IN_PLACE_READ_CMD);
    sel(0, 0, 1);
    repeat (12) @(posedge pclk);
    repeat (8) @(posedge pclk) chk("gas_blank", 32'({bank_a_outputs[1:0], bank_b_outputs}), 32'h20);
    // Clock enable low must hold the scan walk where it stands
    ce <= 1'b0;
    @(posedge pclk);
    v = 32'(scan_outputs);
    repeat (10) @(posedge pclk);
    chk("freeze", 32'(scan_outputs), 32'(v));
    ce <= 1'b1;
    $display("test gas done");
    complete_run();
  end
endmodule : test_keypad_display_refresh_regs
`default_nettype wire
